// File: core/tmios_consts.vh
`ifndef TMIOS_CONSTS_VH
`define TMIOS_CONSTS_VH

// Register byte offsets
`define TMIOS_OFS_SEL0AB    8'h00
`define TMIOS_OFS_SEL0CD    8'h04
`define TMIOS_OFS_SEL1      8'h08
`define TMIOS_OFS_SEL2      8'h0c
`define TMIOS_OFS_MODE0     8'h10
`define TMIOS_OFS_STATUS    8'h14
// General registers: 0x20 + 4 * index
`define TMIOS_GR_HI         3'h1
`define TMIOS_GR_HI_RANGE   7:5
`define TMIOS_GR_IDX_RANGE  4:2

// Reset values
`define TMIOS_SEL_RST       8'h00
`define TMIOS_MODE_RST      2'h0
`define TMIOS_RDATA_RST     32'h0000_0000

// Nibble positions inside a select register
`define TMIOS_NIB_HI        7:4
`define TMIOS_NIB_LO        3:0

// Mode register bits
`define TMIOS_MODE_BFA      0
`define TMIOS_MODE_BFB      1

// Function field bits and codes
`define TMIOS_FN_CAP_BIT    3
`define TMIOS_FN_INIT_BIT   2
`define TMIOS_FN_ACT_RANGE  1:0
`define TMIOS_ACT_OFF       2'h0
`define TMIOS_ACT_LOW       2'h1
`define TMIOS_ACT_HIGH      2'h2
`define TMIOS_ACT_TOG       2'h3
`define TMIOS_CAP_RISE      4'h8
`define TMIOS_CAP_FALL      4'h9
`define TMIOS_CAP_BOTH      4'ha

`endif

// File: core/tmios_unit.v
`timescale 1ns/1ps
`include "tmios_consts.vh"

module tmios_unit #(
    parameter       W        = 16,
    parameter [0:0] CNT1_CAP = 1'b1
) (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire [3:0]   i_func,
    input  wire         i_buffered,
    input  wire [W-1:0] i_count,
    input  wire         i_tick,
    input  wire         i_cnt1_tick,
    input  wire         i_init,
    input  wire         i_pin,
    input  wire         i_gr_we,
    input  wire [W-1:0] i_gr_wdata,
    output reg  [W-1:0] o_gr,
    output reg          o_pin,
    output reg          o_oe_n,
    output reg          o_level
);

    function out_active;
        input [3:0] f;
        input       b;
        begin
            out_active = ~f[`TMIOS_FN_CAP_BIT] & ~b;
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Pin filter: level moves only when stages two and three agree
    reg  [2:0] sync_q;
    wire       agree;
    wire       rise;
    wire       fall;

    assign agree = (sync_q[1] == sync_q[2]);
    assign rise  = agree & sync_q[2] & ~o_level;
    assign fall  = agree & ~sync_q[2] & o_level;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_q  <= 3'h0;
            o_level <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], i_pin};
            if (agree) begin
                o_level <= sync_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Capture and compare
    wire is_cap;
    wire cap_pin;
    wire cap_cnt1;
    wire match;

    assign is_cap   = i_func[`TMIOS_FN_CAP_BIT] & ~i_buffered;
    assign cap_pin  = is_cap & ~i_func[`TMIOS_FN_INIT_BIT] &
                      (((i_func == `TMIOS_CAP_RISE) & rise) |
                       ((i_func == `TMIOS_CAP_FALL) & fall) |
                       ((i_func == `TMIOS_CAP_BOTH) & (rise | fall)));
    assign cap_cnt1 = CNT1_CAP & is_cap & i_func[`TMIOS_FN_INIT_BIT] & i_cnt1_tick;
    assign match    = out_active(i_func, i_buffered) & i_tick & (i_count == o_gr);

    // Capture beats a software write in the same cycle
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gr <= {W{1'b0}};
        end else if (cap_pin | cap_cnt1) begin
            o_gr <= i_count;
        end else if (i_gr_we) begin
            o_gr <= i_gr_wdata;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin  <= 1'b0;
            o_oe_n <= 1'b1;
        end else begin
            o_oe_n <= ~(out_active(i_func, i_buffered) &
                        (i_func[`TMIOS_FN_ACT_RANGE] != `TMIOS_ACT_OFF));
            if (i_init & ~i_func[`TMIOS_FN_CAP_BIT]) begin
                o_pin <= i_func[`TMIOS_FN_INIT_BIT];
            end else if (match) begin
                case (i_func[`TMIOS_FN_ACT_RANGE])
                    `TMIOS_ACT_LOW:  o_pin <= 1'b0;
                    `TMIOS_ACT_HIGH: o_pin <= 1'b1;
                    `TMIOS_ACT_TOG:  o_pin <= ~o_pin;
                    default:         o_pin <= o_pin;
                endcase
            end
        end
    end

endmodule

// File: core/tmios_top.v
// Behaviour
// - Four 8-bit select registers: two for channel 0, one each channels 1, 2.
// - Select registers clear to zero on reset or standby; all bits read/write.
// - A/B registers: bits 7..4 steer register B, bits 3..0 register A.
// - Channel 0 second register: bits 7..4 steer D, bits 3..0 steer C.
// - Bit3 clear: compare; bit2 initial level; 00 no output, 01 low on match.
// - Compare with low bits 10 drives the pin high on match.
// - Compare with low bits 11 toggles the pin on each match.
// - Code 1000 captures on the rising edge of its own pin.
// - Code 1001 captures on the falling edge of its own pin.
// - Code 1010 captures on both edges of its own pin.
// - Bits 3 and 2 set: channel 0 captures on each channel 1 count.
// - Buffered C or D: no capture, no compare, output stays disabled; only the bit2 initial level still loads.
// - Mode register buffer-enable bits put channel 0 C or D in buffer use.
`timescale 1ns/1ps
`include "tmios_consts.vh"

module tmios_top #(
    parameter W = 16
) (
    input  wire         i_clk,
    input  wire         i_resetn,
    input  wire         i_standby,
    input  wire [7:0]   i_avs_address,
    input  wire         i_avs_read,
    input  wire         i_avs_write,
    input  wire [31:0]  i_avs_writedata,
    input  wire [3:0]   i_avs_byteenable,
    output reg  [31:0]  o_avs_readdata,
    output reg          o_avs_waitrequest,
    input  wire [W-1:0] i_count_ch0,
    input  wire [W-1:0] i_count_ch1,
    input  wire [W-1:0] i_count_ch2,
    input  wire [2:0]   i_count_tick,
    input  wire [7:0]   i_tio_pin,
    output wire [7:0]   o_tio_pin,
    output wire [7:0]   o_tio_oe_n
);

    localparam NUNIT = 8;

    function [1:0] unit_chan;
        input integer idx;
        begin
            if (idx < 4) begin
                unit_chan = 2'd0;
            end else if (idx < 6) begin
                unit_chan = 2'd1;
            end else begin
                unit_chan = 2'd2;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Reset release
    reg [1:0] rst_q;
    wire      rst_n;

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////
    // Bus handshake
    // One wait cycle per access keeps read data registered
    wire       req;
    wire       wr_go;
    wire       rd_load;
    wire [31:0] be_mask;

    assign req     = i_avs_read | i_avs_write;
    assign wr_go   = i_avs_write & ~o_avs_waitrequest;
    assign rd_load = i_avs_read & o_avs_waitrequest;
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Select and mode registers
    reg  [7:0] sel0ab_q;
    reg  [7:0] sel0cd_q;
    reg  [7:0] sel1_q;
    reg  [7:0] sel2_q;
    reg  [1:0] mode0_q;
    reg  [3:0] init_q;
    wire [3:0] wr_sel;
    wire       wr_lane0;

    assign wr_lane0  = wr_go & i_avs_byteenable[0];
    assign wr_sel[0] = wr_lane0 & (i_avs_address == `TMIOS_OFS_SEL0AB);
    assign wr_sel[1] = wr_lane0 & (i_avs_address == `TMIOS_OFS_SEL0CD);
    assign wr_sel[2] = wr_lane0 & (i_avs_address == `TMIOS_OFS_SEL1);
    assign wr_sel[3] = wr_lane0 & (i_avs_address == `TMIOS_OFS_SEL2);

    // Standby wins over a write in the same cycle
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel0ab_q <= `TMIOS_SEL_RST;
            sel0cd_q <= `TMIOS_SEL_RST;
            sel1_q   <= `TMIOS_SEL_RST;
            sel2_q   <= `TMIOS_SEL_RST;
        end else if (i_standby) begin
            sel0ab_q <= `TMIOS_SEL_RST;
            sel0cd_q <= `TMIOS_SEL_RST;
            sel1_q   <= `TMIOS_SEL_RST;
            sel2_q   <= `TMIOS_SEL_RST;
        end else begin
            if (wr_sel[0]) begin
                sel0ab_q <= i_avs_writedata[7:0];
            end
            if (wr_sel[1]) begin
                sel0cd_q <= i_avs_writedata[7:0];
            end
            if (wr_sel[2]) begin
                sel1_q <= i_avs_writedata[7:0];
            end
            if (wr_sel[3]) begin
                sel2_q <= i_avs_writedata[7:0];
            end
        end
    end

    // Initial pin level is applied the cycle after the new field lands
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= 4'h0;
        end else begin
            init_q <= wr_sel | {4{i_standby}};
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode0_q <= `TMIOS_MODE_RST;
        end else if (wr_lane0 & (i_avs_address == `TMIOS_OFS_MODE0)) begin
            mode0_q <= i_avs_writedata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Function fields per general register
    // Order: ch0 A, B, C, D, ch1 A, B, ch2 A, B
    wire [4*NUNIT-1:0] func_flat;
    wire [NUNIT-1:0]   buffered;
    wire [3*W-1:0]     count_flat;
    wire [W*NUNIT-1:0] gr_flat;
    wire [NUNIT-1:0]   level;

    assign func_flat = {sel2_q[`TMIOS_NIB_HI], sel2_q[`TMIOS_NIB_LO],
                        sel1_q[`TMIOS_NIB_HI], sel1_q[`TMIOS_NIB_LO],
                        sel0cd_q[`TMIOS_NIB_HI], sel0cd_q[`TMIOS_NIB_LO],
                        sel0ab_q[`TMIOS_NIB_HI], sel0ab_q[`TMIOS_NIB_LO]};

    // Only channel 0 C and D can be buffered
    assign buffered = {4'h0, mode0_q[`TMIOS_MODE_BFB], mode0_q[`TMIOS_MODE_BFA], 2'h0};

    assign count_flat = {i_count_ch2, i_count_ch1, i_count_ch0};

    ////////////////////////////////////////////////////////////////
    // Units
    genvar g;
    generate
        for (g = 0; g < NUNIT; g = g + 1) begin : g_unit
            localparam [1:0] CH  = unit_chan(g);
            localparam [2:0] IDX = g;
            wire [W-1:0] old_gr;
            wire [W-1:0] new_gr;
            wire         gr_we;

            assign old_gr = gr_flat[g*W +: W];
            assign new_gr = (old_gr & ~be_mask[W-1:0]) | (i_avs_writedata[W-1:0] & be_mask[W-1:0]);
            assign gr_we  = wr_go & (i_avs_address[`TMIOS_GR_HI_RANGE] == `TMIOS_GR_HI) &
                            (i_avs_address[`TMIOS_GR_IDX_RANGE] == IDX);

            tmios_unit #(
                .W        (W),
                .CNT1_CAP ((g < 4) ? 1'b1 : 1'b0)
            ) u_unit (
                .i_clk       (i_clk),
                .i_rst_n     (rst_n),
                .i_func      (func_flat[4*g +: 4]),
                .i_buffered  (buffered[g]),
                .i_count     (count_flat[CH*W +: W]),
                .i_tick      (i_count_tick[CH]),
                .i_cnt1_tick (i_count_tick[1]),
                .i_init      (init_q[g/2]),
                .i_pin       (i_tio_pin[g]),
                .i_gr_we     (gr_we),
                .i_gr_wdata  (new_gr),
                .o_gr        (gr_flat[g*W +: W]),
                .o_pin       (o_tio_pin[g]),
                .o_oe_n      (o_tio_oe_n[g]),
                .o_level     (level[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Read path
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = `TMIOS_RDATA_RST;
        if (i_avs_address == `TMIOS_OFS_SEL0AB) begin
            rdata_d = {24'h0, sel0ab_q};
        end else if (i_avs_address == `TMIOS_OFS_SEL0CD) begin
            rdata_d = {24'h0, sel0cd_q};
        end else if (i_avs_address == `TMIOS_OFS_SEL1) begin
            rdata_d = {24'h0, sel1_q};
        end else if (i_avs_address == `TMIOS_OFS_SEL2) begin
            rdata_d = {24'h0, sel2_q};
        end else if (i_avs_address == `TMIOS_OFS_MODE0) begin
            rdata_d = {30'h0, mode0_q};
        end else if (i_avs_address == `TMIOS_OFS_STATUS) begin
            rdata_d = {16'h0, o_tio_pin, level};
        end else if (i_avs_address[`TMIOS_GR_HI_RANGE] == `TMIOS_GR_HI) begin
            rdata_d = {{(32-W){1'b0}}, gr_flat[i_avs_address[`TMIOS_GR_IDX_RANGE]*W +: W]};
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_avs_readdata <= `TMIOS_RDATA_RST;
        end else if (rd_load) begin
            o_avs_readdata <= rdata_d;
        end
    end

endmodule

// File: verification/tmios_checker.sv
`timescale 1ns/1ps
module tmios_checker (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_standby,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [2:0]  i_count_tick,
    input wire logic [7:0]  o_tio_pin,
    input wire logic [7:0]  o_tio_oe_n
);
    logic req;
    assign req = i_avs_read | i_avs_write;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    sequence s_taken;
        req && o_avs_waitrequest;
    endsequence
    sequence s_read_done;
        i_avs_read && !o_avs_waitrequest;
    endsequence
    // Pins may only move after a tick, a write or standby
    sequence s_quiet;
        !i_standby && i_count_tick == 3'h0 && !i_avs_write;
    endsequence
    ////////////////////////////////////////
    a_wait_answer: assert property (s_taken |-> ##[1:3] !o_avs_waitrequest)
        else $error("bus request never answered");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (!o_avs_waitrequest |-> $past(req && o_avs_waitrequest))
        else $error("waitrequest low without a request");
    a_rdata_cause: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (s_read_done ##0 i_avs_address inside {8'h18, 8'h1c}
        |-> o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    a_upper_zero: assert property (s_read_done ##0 i_avs_address < 8'h10 |-> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("select register upper bits not zero");
    a_standby_clear: assert property (i_standby |-> ##2 o_tio_oe_n == 8'hff)
        else $error("standby left an output enabled");
    a_oe_cause: assert property ($changed(o_tio_oe_n) |->
        $past(i_avs_write && !o_avs_waitrequest, 2) || $past(i_standby) || $past(i_standby, 2))
        else $error("output enable moved without a select change");
    a_pins_quiet: assert property (s_quiet [*4] |=> $stable(o_tio_pin) && $stable(o_tio_oe_n))
        else $error("pin moved without cause");
endmodule
bind tmios_top tmios_checker tmios_checker_inst (.i_clk, .i_resetn, .i_standby, .i_avs_address, .i_avs_read,
    .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_count_tick, .o_tio_pin, .o_tio_oe_n);

// File: verification/tmios_pin_model.sv
`timescale 1ns/1ps
// Far side pins: device drive wins where enabled, else the far level
module tmios_pin_model (
    input  wire logic [7:0] i_far,
    input  wire logic [7:0] i_pin_drive,
    input  wire logic [7:0] i_oe_n,
    output wire logic [7:0] o_wire
);
    assign o_wire = (i_pin_drive & ~i_oe_n) | (i_far & i_oe_n);
endmodule

// File: verification/tmios_top_bench.sv
`timescale 1ns/1ps
module tmios_top_bench;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_standby = 1'b0;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [15:0] i_count_ch0 = 16'h0, i_count_ch1 = 16'h0, i_count_ch2 = 16'h0;
    logic [2:0]  i_count_tick = 3'h0;
    logic [7:0]  far = 8'h00;
    wire  [31:0] o_avs_readdata;
    wire         o_avs_waitrequest;
    wire  [7:0]  i_tio_pin, o_tio_pin, o_tio_oe_n;
    int          errors = 0, num_checks = 0, u, ch;
    logic [31:0] rd, e;
    logic [7:0]  sel, gr;
    logic [3:0]  c, sh;
    logic [15:0] v;

    always #50 i_clk = ~i_clk;

    tmios_top #(.W(16)) tmios_top_inst (.i_clk, .i_resetn, .i_standby, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .i_count_ch0, .i_count_ch1, .i_count_ch2, .i_count_tick, .i_tio_pin, .o_tio_pin, .o_tio_oe_n);
    tmios_pin_model tmios_pin_model_inst (.i_far(far), .i_pin_drive(o_tio_pin), .i_oe_n(o_tio_oe_n),
        .o_wire(i_tio_pin));
    ////////////////////////////////////////
    task print_verdict;
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask
    // Level only matters while the pin is driven
    task chk_pin(input int k, input logic oe_n, input logic lvl);
        num_checks++;
        if (o_tio_oe_n[k] !== oe_n || (!oe_n && o_tio_pin[k] !== lvl)) begin
            errors++;
            $display("BAD %0t pin %0d enable %b level %b", $time, k, o_tio_oe_n[k], o_tio_pin[k]);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (o_avs_waitrequest !== 1'b0)
            errors++;
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Counter value, one tick on channel k (3 = none), far pin levels
    task step(input int k, input logic [15:0] cv, input logic [7:0] f);
        @(posedge i_clk);
        {i_count_ch0, i_count_ch1, i_count_ch2} <= {3{cv}};
        i_count_tick <= 3'h1 << k;
        far <= f;
        @(posedge i_clk);
        i_count_tick <= 3'h0;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task unit(input int k);
        sel = (k < 4) ? 8'(k / 2 * 4) : (k < 6) ? 8'h08 : 8'h0c;
        sh = (k % 2) ? 4'h4 : 4'h0;
        ch = (k < 4) ? 0 : (k < 6) ? 1 : 2;
        gr = 8'(8'h20 + 4 * k);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        for (u = 0; u < 6; u++) rdc(8'(u * 4), 32'h0);
        for (u = 0; u < 4; u++) begin
            wr(8'(u * 4), 32'hffff_ff5a ^ u);
            rdc(8'(u * 4), 32'h5a ^ u);
        end
        wr(8'h18, 32'hff);
        rdc(8'h18, 32'h0);
        @(posedge i_clk);
        i_standby <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_standby <= 1'b0;
        for (u = 0; u < 4; u++) rdc(8'(u * 4), 32'h0);
        // Compare codes 0 to 7 on every unit
        for (u = 0; u < 8; u++) begin
            unit(u);
            for (c = 0; c < 8; c++) begin
                v = 16'h0700 + 16'(u);
                wr(gr, {16'h0, v});
                wr(sel, {24'h0, 8'(c) << sh});
                step(ch, ~v, 8'h00);
                chk_pin(u, c[1:0] == 2'h0, c[2]);
                step(ch, v, 8'h00);
                chk_pin(u, c[1:0] == 2'h0, c[1:0] == 2'h1 ? 1'b0 : c[1:0] == 2'h2 ? 1'b1 : !c[2]);
            end
        end
        // Pin edges, then a channel 1 count, per capture code
        for (u = 0; u < 8; u++) begin
            unit(u);
            for (c = 4'h8; c <= 4'hc; c++) begin
                wr(sel, {24'h0, 8'(c) << sh});
                wr(gr, 32'h0);
                step(3, 16'h1100 + 16'(u), 8'h1 << u);
                e = (c == 4'h8 || c == 4'ha) ? 32'h1100 + u : 32'h0;
                rdc(gr, e);
                step(3, 16'h2200 + 16'(u), 8'h00);
                e = (c == 4'h9 || c == 4'ha) ? 32'h2200 + u : e;
                rdc(gr, e);
                step(1, 16'h3300 + 16'(u), 8'h00);
                rdc(gr, (c == 4'hc && u < 4) ? 32'h3300 + u : e);
            end
        end
        // Buffer enables: bit 0 steers C, bit 1 steers D
        wr(8'h10, 32'h1);
        wr(8'h04, 32'h22);
        step(0, 16'h0, 8'h00);
        chk_pin(2, 1'b1, 1'b0);
        chk_pin(3, 1'b0, 1'b0);
        wr(8'h10, 32'h3);
        rdc(8'h10, 32'h3);
        wr(8'h28, 32'h5);
        step(0, 16'h5, 8'h00);
        chk_pin(3, 1'b1, 1'b0);
        wr(8'h04, 32'h88);
        step(3, 16'h9, 8'h04);
        rdc(8'h28, 32'h5);
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        errors++;
        print_verdict();
    end
endmodule
